// [ntp_table_nvm.v]
// Table pointer, table latch, page buffer and NVM command engine.
// Assumes a CPU front end on the same clock and a flash array with a
// one-cycle synchronous read port and a write strobe port.
//
// Summary of operation
// - Interrupted flash write sets write error flag
// - Address picks space; device ID read-only
// - Config bytes written singly, erased first
// - Config write cannot disable protection
// - Pointer is upper:high:low, 22 bits
// - Bits 0-20 program, bit 21 info areas
// - Inc/dec touch only pointer bits 0-20
// - None, post-inc, post-dec, pre-inc variants
// - Latch captures reads, feeds writes
// - Table read uses pointer bits 0-20 only
// - Table write lands in page buffer
// - Page write uses address upper bits
// - Table read stalls CPU one cycle
// - Address LSB selects word byte
// - Byte access, no alignment enforced
// - Commands 0x02 read, 0x06 erase, 0x05 write
// - Write done clears go, sets done flag
// - Protected/invalid target: error, no effect
`timescale 1ns/10ps
`default_nettype none
`include "ntp_regs.vh"
module ntp_table_nvm #(
   parameter PAGE_BYTES = 256,
   parameter PAGE_AW = 8,
   parameter CFG_BYTES = 16,
   parameter [7:0] CFG_PROTECT_MASK = 8'h01,
   parameter [21:0] PROG_LIMIT = 22'h010000,
   parameter [21:0] USERID_BASE = 22'h200000,
   parameter [21:0] CFG_BASE = 22'h300000,
   parameter [21:0] DEVID_BASE = 22'h3FFFFC,
   parameter [7:0] DEVID_BYTE = 8'h5A // Arbitrary identity value
) (
   input wire core_clk_in,
   input wire reset_n_in,
   input wire wd_or_master_clear_reset_rst_in,
   input wire sfr_wr_in,
   input wire [3:0] sfr_sel_in,
   input wire [7:0] sfr_wdata_in,
   output reg [7:0] sfr_rdata_out,
   input wire tbl_rd_in,
   input wire tbl_wr_in,
   input wire [1:0] tbl_mode_in,
   output wire cpu_stall_out,
   output wire [20:0] flash_addr_out,
   output wire flash_rd_out,
   input wire [15:0] flash_word_in,
   output reg flash_wr_out,
   output reg flash_erase_out,
   output reg [15:0] flash_wdata_out,
   output wire nvm_irq_out
);
   localparam [31:0] WR_CYC = (`NTP_WR_TIME_NS + `NTP_CLK_NS - 32'd1) / `NTP_CLK_NS;
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_TRD = 4'b0010;
   localparam [3:0] ST_BUSY = 4'b0100;
   localparam [3:0] ST_NRD = 4'b1000;

   reg [21:0] ptr_ff;
   reg [7:0] latch_ff;
   reg [21:0] adr_ff;
   reg [7:0] dat_ff;
   reg [2:0] cmd_ff;
   reg go_ff;
   reg done_ff;
   reg werr_ff;
   reg ie_ff;
   reg [1:0] lock_ff;
   reg [3:0] st_ff;
   reg [8:0] cnt_ff;
   reg [PAGE_AW:0] idx_ff;
   reg [1:0] rmode_ff;
   reg [20:0] waddr_ff;
   reg [7:0] pbuf [0:PAGE_BYTES-1];
   reg [7:0] cfg_mem [0:CFG_BYTES-1];
   wire [7:0] merged;
   wire [21:0] eff_ptr;
   wire [7:0] fbyte;
   wire go_req;
   wire unlocked;
   wire adr_prog;
   wire adr_uid;
   wire adr_cfg;
   wire adr_dev;
   wire ok_write;
   wire refuse_op;

   // Pointer step limited to bits 0-20, bit 21 preserved
   function [21:0] ptr_step;
      input [21:0] p;
      input up;
      begin
         ptr_step = {p[21], up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001};
      end
   endfunction

   // Pick byte of a 16-bit word by the address LSB
   function [7:0] word_byte;
      input [15:0] w;
      input lsb;
      begin
         word_byte = lsb ? w[15:8] : w[7:0];
      end
   endfunction

   // Address space decode
   assign adr_prog = (adr_ff[21] == 1'b0) && (adr_ff < PROG_LIMIT);
   assign adr_uid = (adr_ff >= USERID_BASE) && (adr_ff < USERID_BASE + 22'h000010);
   assign adr_cfg = (adr_ff >= CFG_BASE) && (adr_ff < CFG_BASE + CFG_BYTES);
   assign adr_dev = (adr_ff >= DEVID_BASE);
   assign ok_write = ((cmd_ff == `NTP_CMD_BYTE_WR) && (adr_cfg || adr_prog || adr_uid)) ||
                     ((cmd_ff != `NTP_CMD_BYTE_WR) && (adr_prog || adr_uid));
   assign unlocked = (lock_ff == 2'b10);
   // One refusal term shared by the engine and the error flag; only the engine lets a table op in the same cycle win
   assign refuse_op = !unlocked || !ok_write ||
                      !(cmd_ff == `NTP_CMD_BYTE_WR || cmd_ff == `NTP_CMD_PAGE_WR ||
                        cmd_ff == `NTP_CMD_PAGE_ER);
   assign go_req = sfr_wr_in && (sfr_sel_in == `NTP_SFR_CTRL) && sfr_wdata_in[`NTP_CTRL_GO] && !go_ff;

   // Pre-increment pointer feeds the access address
   assign eff_ptr = (tbl_mode_in == `NTP_TOP_PREINC) ? ptr_step(ptr_ff, 1'b1) : ptr_ff;
   assign flash_rd_out = (st_ff == ST_IDLE) && tbl_rd_in ||
                         (st_ff == ST_IDLE) && go_req && !go_ff ||
                         (st_ff == ST_NRD);
   // Write strobes are registered, so their address is registered with them
   assign flash_addr_out = (st_ff == ST_NRD) ? {adr_ff[20:PAGE_AW], idx_ff[PAGE_AW-1:0]} :
                           (st_ff == ST_BUSY) ? waddr_ff :
                           (tbl_rd_in ? eff_ptr[20:0] : adr_ff[20:0]);
   assign fbyte = word_byte(flash_word_in, rmode_ff[0]);
   assign cpu_stall_out = (st_ff == ST_IDLE) && tbl_rd_in;
   assign nvm_irq_out = done_ff && ie_ff;

   ntp_cfg_merge u_merge (
      .old_byte_in(cfg_mem[adr_ff[3:0]]),
      .new_byte_in(dat_ff),
      .protect_mask_in(CFG_PROTECT_MASK),
      .merged_out(merged)
   );

   // Register read mux
   always @* begin
      case (sfr_sel_in)
         `NTP_SFR_PTRL: sfr_rdata_out = ptr_ff[7:0];
         `NTP_SFR_PTRH: sfr_rdata_out = ptr_ff[15:8];
         `NTP_SFR_PTRU: sfr_rdata_out = {2'h0, ptr_ff[21:16]};
         `NTP_SFR_LATCH: sfr_rdata_out = latch_ff;
         `NTP_SFR_ADRL: sfr_rdata_out = adr_ff[7:0];
         `NTP_SFR_ADRH: sfr_rdata_out = adr_ff[15:8];
         `NTP_SFR_ADRU: sfr_rdata_out = {2'h0, adr_ff[21:16]};
         `NTP_SFR_DAT: sfr_rdata_out = dat_ff;
         `NTP_SFR_CMD: sfr_rdata_out = {5'h00, cmd_ff};
         `NTP_SFR_CTRL: sfr_rdata_out = {4'h0, ie_ff, werr_ff, done_ff, go_ff};
         default: sfr_rdata_out = 8'h00;
      endcase
   end

   // Page buffer: table writes and page reads; single write port
   always @(posedge core_clk_in) begin
      if (st_ff == ST_IDLE && tbl_wr_in) begin
         pbuf[eff_ptr[PAGE_AW-1:0]] <= latch_ff;
      end else if (st_ff == ST_NRD && idx_ff != 0) begin
         pbuf[idx_ff[PAGE_AW-1:0] - 1'b1] <= fbyte;
      end
   end

   // Configuration byte store with auto-erase-then-program
   always @(posedge core_clk_in) begin
      if (st_ff == ST_BUSY && cmd_ff == `NTP_CMD_BYTE_WR && adr_cfg && cnt_ff == 9'h001) begin
         cfg_mem[adr_ff[3:0]] <= merged;
      end
   end

   // Main control: pointer, latch, SFRs and command engine
   always @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         ptr_ff <= 22'h000000;
         latch_ff <= 8'h00;
         adr_ff <= 22'h000000;
         dat_ff <= 8'h00;
         cmd_ff <= 3'h0;
         go_ff <= 1'b0;
         done_ff <= 1'b0;
         ie_ff <= 1'b0;
         lock_ff <= 2'b00;
         st_ff <= ST_IDLE;
         cnt_ff <= 9'h000;
         idx_ff <= {(PAGE_AW+1){1'b0}};
         rmode_ff <= 2'b00;
         waddr_ff <= 21'h000000;
         flash_wr_out <= 1'b0;
         flash_erase_out <= 1'b0;
         flash_wdata_out <= 16'h0000;
      end else begin
         flash_wr_out <= 1'b0;
         flash_erase_out <= 1'b0;
         // SFR writes, frozen while an operation runs
         if (sfr_wr_in && !go_ff) begin
            case (sfr_sel_in)
               `NTP_SFR_PTRL: ptr_ff[7:0] <= sfr_wdata_in;
               `NTP_SFR_PTRH: ptr_ff[15:8] <= sfr_wdata_in;
               `NTP_SFR_PTRU: ptr_ff[21:16] <= sfr_wdata_in[5:0];
               `NTP_SFR_LATCH: latch_ff <= sfr_wdata_in;
               `NTP_SFR_ADRL: adr_ff[7:0] <= sfr_wdata_in;
               `NTP_SFR_ADRH: adr_ff[15:8] <= sfr_wdata_in;
               `NTP_SFR_ADRU: adr_ff[21:16] <= sfr_wdata_in[5:0];
               `NTP_SFR_DAT: dat_ff <= sfr_wdata_in;
               `NTP_SFR_CMD: cmd_ff <= sfr_wdata_in[2:0];
               `NTP_SFR_CTRL: begin
                  ie_ff <= sfr_wdata_in[`NTP_CTRL_IE];
                  if (!sfr_wdata_in[`NTP_CTRL_DONE]) begin
                     done_ff <= 1'b0;
                  end
               end
               default: ;
            endcase
         end
         // Unlock tracker: 0x55 then 0xAA, any other write resets
         if (sfr_wr_in && sfr_sel_in == `NTP_SFR_LOCK) begin
            lock_ff <= (sfr_wdata_in == `NTP_KEY1) ? 2'b01 :
                       (sfr_wdata_in == `NTP_KEY2 && lock_ff == 2'b01) ? 2'b10 : 2'b00;
         end else if (go_req) begin
            lock_ff <= 2'b00;
         end
         case (st_ff)
            ST_IDLE: begin
               if (tbl_rd_in) begin
                  rmode_ff <= {eff_ptr[21], eff_ptr[0]};
                  st_ff <= ST_TRD;
                  if (tbl_mode_in == `NTP_TOP_PREINC || tbl_mode_in == `NTP_TOP_POSTINC) begin
                     ptr_ff <= ptr_step(ptr_ff, 1'b1);
                  end else if (tbl_mode_in == `NTP_TOP_POSTDEC) begin
                     ptr_ff <= ptr_step(ptr_ff, 1'b0);
                  end
               end else if (tbl_wr_in) begin
                  if (tbl_mode_in == `NTP_TOP_PREINC || tbl_mode_in == `NTP_TOP_POSTINC) begin
                     ptr_ff <= ptr_step(ptr_ff, 1'b1);
                  end else if (tbl_mode_in == `NTP_TOP_POSTDEC) begin
                     ptr_ff <= ptr_step(ptr_ff, 1'b0);
                  end
               end else if (go_req) begin
                  if (cmd_ff == `NTP_CMD_BYTE_RD) begin
                     // Byte read answers next cycle through the table read state into DAT
                     rmode_ff <= {adr_ff[21], adr_ff[0]};
                     go_ff <= 1'b1;
                     cnt_ff <= 9'h000;
                     st_ff <= ST_TRD;
                  end else if (cmd_ff == `NTP_CMD_PAGE_RD && adr_prog) begin
                     go_ff <= 1'b1;
                     idx_ff <= {(PAGE_AW+1){1'b0}};
                     st_ff <= ST_NRD;
                  end else if (refuse_op) begin
                     go_ff <= 1'b0;
                  end else begin
                     go_ff <= 1'b1;
                     idx_ff <= {(PAGE_AW+1){1'b0}};
                     cnt_ff <= WR_CYC[8:0];
                     waddr_ff <= adr_ff[20:0];
                     flash_erase_out <= (cmd_ff == `NTP_CMD_PAGE_ER);
                     st_ff <= ST_BUSY;
                  end
               end
            end
            ST_TRD: begin
               // Latch loads from flash; DAT loads from flash, config store or ID byte
               if (go_ff) begin
                  dat_ff <= adr_cfg ? cfg_mem[adr_ff[3:0]] : adr_dev ? DEVID_BYTE : fbyte;
                  go_ff <= 1'b0;
                  done_ff <= 1'b1;
               end else begin
                  latch_ff <= fbyte;
               end
               st_ff <= ST_IDLE;
            end
            ST_NRD: begin
               // One byte per cycle, flash data lags address by one
               idx_ff <= idx_ff + 1'b1;
               rmode_ff <= {1'b0, idx_ff[0]};
               if (idx_ff == PAGE_BYTES) begin
                  go_ff <= 1'b0;
                  done_ff <= 1'b1;
                  st_ff <= ST_IDLE;
               end
            end
            ST_BUSY: begin
               if (cmd_ff == `NTP_CMD_PAGE_WR && idx_ff < PAGE_BYTES) begin
                  // Whole buffer goes to the page picked by address upper bits
                  flash_wdata_out <= {pbuf[{idx_ff[PAGE_AW-1:1], 1'b1}], pbuf[{idx_ff[PAGE_AW-1:1], 1'b0}]};
                  flash_wr_out <= 1'b1;
                  waddr_ff <= {adr_ff[20:PAGE_AW], idx_ff[PAGE_AW-1:0]};
                  idx_ff <= idx_ff + 2'd2;
               end else if (cmd_ff == `NTP_CMD_BYTE_WR && adr_prog && cnt_ff == 9'h002) begin
                  // Issued one cycle early so the strobe still falls inside the busy state
                  flash_wdata_out <= {dat_ff, dat_ff};
                  flash_wr_out <= 1'b1;
               end
               if (cnt_ff > 9'h000) begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
               if (cnt_ff <= 9'h001 && (cmd_ff != `NTP_CMD_PAGE_WR || idx_ff >= PAGE_BYTES)) begin
                  go_ff <= 1'b0;
                  done_ff <= 1'b1;
                  st_ff <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // Error flag survives the reset that interrupts a write
   always @(posedge core_clk_in) begin
      if (wd_or_master_clear_reset_rst_in && go_ff && st_ff == ST_BUSY) begin
         werr_ff <= 1'b1;
      end else if (!reset_n_in && !wd_or_master_clear_reset_rst_in) begin
         // A reset of that cause keeps the flag on every edge it is held
         werr_ff <= 1'b0;
      end else if (st_ff == ST_IDLE && go_req && cmd_ff != `NTP_CMD_BYTE_RD &&
                   !(cmd_ff == `NTP_CMD_PAGE_RD && adr_prog) && refuse_op) begin
         werr_ff <= 1'b1;
      end else if (sfr_wr_in && sfr_sel_in == `NTP_SFR_CTRL && !sfr_wdata_in[`NTP_CTRL_WERR]) begin
         werr_ff <= 1'b0;
      end
   end
endmodule // ntp_table_nvm
`default_nettype wire

// [ntp_regs.vh]
// Constants for the table pointer and NVM command logic.
// Included by the design files; holds definitions only.
`ifndef NTP_REGS_VH
`define NTP_REGS_VH
// SFR selectors on the register port
`define NTP_SFR_PTRL 4'h0
`define NTP_SFR_PTRH 4'h1
`define NTP_SFR_PTRU 4'h2
`define NTP_SFR_LATCH 4'h3
`define NTP_SFR_ADRL 4'h4
`define NTP_SFR_ADRH 4'h5
`define NTP_SFR_ADRU 4'h6
`define NTP_SFR_DAT 4'h7
`define NTP_SFR_CMD 4'h8
`define NTP_SFR_CTRL 4'h9
`define NTP_SFR_LOCK 4'hA
// Command field encodings
`define NTP_CMD_BYTE_RD 3'h0
`define NTP_CMD_PAGE_RD 3'h2
`define NTP_CMD_BYTE_WR 3'h3
`define NTP_CMD_PAGE_WR 3'h5
`define NTP_CMD_PAGE_ER 3'h6
// Control register fields
`define NTP_CTRL_GO 0
`define NTP_CTRL_DONE 1
`define NTP_CTRL_WERR 2
`define NTP_CTRL_IE 3
// Table op variants
`define NTP_TOP_NONE 2'h0
`define NTP_TOP_POSTINC 2'h1
`define NTP_TOP_POSTDEC 2'h2
`define NTP_TOP_PREINC 2'h3
// Unlock keys
`define NTP_KEY1 8'h55
`define NTP_KEY2 8'hAA
// Pointer layout
`define NTP_PTR_W 22
`define NTP_PTR_SPACE_BIT 21
// Write time in ns, programming timer
`define NTP_WR_TIME_NS 32'd2000
`define NTP_CLK_NS 32'd50
`endif

// [ntp_cfg_merge.v]
// Merges a new configuration byte with the stored one.
// Assumes protect_mask marks bits whose 0 value means protection on.
`timescale 1ns/10ps
`default_nettype none
module ntp_cfg_merge (
   input wire [7:0] old_byte_in,
   input wire [7:0] new_byte_in,
   input wire [7:0] protect_mask_in,
   output wire [7:0] merged_out
);
   // Protect bits are active low: a 0 already stored stays 0
   assign merged_out = (new_byte_in & ~protect_mask_in) |
                       (new_byte_in & old_byte_in & protect_mask_in);
endmodule // ntp_cfg_merge
`default_nettype wire

// [ntp_table_nvm_sva.sv]
// Port-level assertions for the table pointer and NVM engine.
// Assumes it is bound onto ntp_table_nvm, one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "ntp_regs.vh"
module ntp_table_nvm_sva (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic sfr_wr_in,
   input wire logic [3:0] sfr_sel_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic tbl_rd_in,
   input wire logic tbl_wr_in,
   input wire logic cpu_stall_out,
   input wire logic flash_rd_out,
   input wire logic flash_wr_out,
   input wire logic flash_erase_out,
   input wire logic nvm_irq_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // Stall belongs to a table read, fetches flash and lasts one cycle
   chk_stall_cause: assert property (cpu_stall_out |-> tbl_rd_in)
      else $error("stall without table read");
   chk_stall_fetch: assert property (cpu_stall_out |-> flash_rd_out)
      else $error("table read without flash fetch");
   chk_stall_once: assert property (cpu_stall_out |=> !cpu_stall_out)
      else $error("stall longer than one cycle");
   // Interrupt mirrors done and enable, and stands until software clears it
   chk_irq_flags: assert property (sfr_sel_in == `NTP_SFR_CTRL |->
      nvm_irq_out == (sfr_rdata_out[1] & sfr_rdata_out[3])) else $error("irq differs from flags");
   chk_irq_hold: assert property (nvm_irq_out && !(sfr_wr_in && sfr_sel_in == `NTP_SFR_CTRL) |=> nvm_irq_out)
      else $error("irq dropped without clear");
   // Reset must leave no strobe behind; checked during reset itself
   chk_reset_quiet: assert property (disable iff (1'h0)
      !reset_n_in |=> !flash_wr_out && !flash_erase_out && !nvm_irq_out) else $error("strobe after reset");
   // Pointer only moves after a register write or a table op
   chk_ptr_hold: assert property (sfr_sel_in == `NTP_SFR_PTRL && $stable(sfr_sel_in) && !$past(sfr_wr_in)
      && !$past(tbl_rd_in) && !$past(tbl_rd_in, 2) && !$past(tbl_wr_in) && !$past(tbl_wr_in, 2)
      |-> $stable(sfr_rdata_out)) else $error("pointer moved on its own");
   chk_strobe_excl: assert property (!(flash_wr_out && flash_erase_out))
      else $error("erase and write together");
   // Main scenarios
   cover property (cpu_stall_out);
   cover property (nvm_irq_out);
   cover property (flash_wr_out);
endmodule // ntp_table_nvm_sva
bind ntp_table_nvm ntp_table_nvm_sva ntp_table_nvm_sva_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
   .sfr_wr_in(sfr_wr_in), .sfr_sel_in(sfr_sel_in), .sfr_rdata_out(sfr_rdata_out), .tbl_rd_in(tbl_rd_in),
   .tbl_wr_in(tbl_wr_in), .cpu_stall_out(cpu_stall_out), .flash_rd_out(flash_rd_out),
   .flash_wr_out(flash_wr_out), .flash_erase_out(flash_erase_out), .nvm_irq_out(nvm_irq_out));
`default_nettype wire

// [ntp_flash_model.sv]
// Behavioural program flash array beside the NVM engine.
// Assumes one-cycle synchronous reads and single-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module ntp_flash_model (
   input wire logic core_clk_in,
   input wire logic [20:0] flash_addr_in,
   input wire logic flash_rd_in,
   input wire logic flash_wr_in,
   input wire logic flash_erase_in,
   input wire logic [15:0] flash_wdata_in,
   output logic [15:0] flash_word_out
);
   logic [15:0] mem [int];
   // Keyed by word address; unwritten words hold an address pattern so a wrong fetch shows
   function automatic logic [15:0] peek(input logic [20:0] a);
      return mem.exists(a) ? mem[a] : {a[7:0] ^ 8'hA5, a[7:0]};
   endfunction
   initial flash_word_out = 16'h0000;
   // Data is valid only the cycle after a read; otherwise it toggles
   always @(posedge core_clk_in) begin
      if (flash_rd_in) flash_word_out <= peek({1'b0, flash_addr_in[20:1]});
      else flash_word_out <= ~flash_word_out;
      // Erase clears the whole 128-word page around the address
      if (flash_erase_in) begin
         for (int i = 0; i < 128; i++) mem[{flash_addr_in[20:8], i[6:0]}] = 16'hFFFF;
      end
      if (flash_wr_in) mem[{1'b0, flash_addr_in[20:1]}] = flash_wdata_in;
   end
endmodule // ntp_flash_model
`default_nettype wire

// [ntp_table_nvm_tb.sv]
// Self-checking bench for the table pointer and NVM engine.
// Assumes the flash model and the bound checker are compiled too.
`timescale 1ns/10ps
`default_nettype none
`include "ntp_regs.vh"
module ntp_table_nvm_tb;
   logic clk = 1'h0, rst_n = 1'h0, wdrst = 1'h0, swr = 1'h0, trd = 1'h0, twr = 1'h0;
   logic [3:0] sel = 4'h0;
   logic [7:0] wdat = 8'h00, rdat;
   logic [1:0] mode = 2'h0;
   logic stall, frd, fwr, fer, irq;
   logic [20:0] faddr;
   logic [15:0] fword, fwdat;
   int err_total = 0, n_checks = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   ntp_table_nvm ntp_table_nvm_i (.core_clk_in(clk), .reset_n_in(rst_n), .wd_or_master_clear_reset_rst_in(wdrst),
      .sfr_wr_in(swr), .sfr_sel_in(sel), .sfr_wdata_in(wdat), .sfr_rdata_out(rdat), .tbl_rd_in(trd),
      .tbl_wr_in(twr), .tbl_mode_in(mode), .cpu_stall_out(stall), .flash_addr_out(faddr), .flash_rd_out(frd),
      .flash_word_in(fword), .flash_wr_out(fwr), .flash_erase_out(fer), .flash_wdata_out(fwdat), .nvm_irq_out(irq));
   ntp_flash_model ntp_flash_model_i (.core_clk_in(clk), .flash_addr_in(faddr), .flash_rd_in(frd),
      .flash_wr_in(fwr), .flash_erase_in(fer), .flash_wdata_in(fwdat), .flash_word_out(fword));
   // Compare, print and count
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Register port: strobe one cycle, then a quiet cycle before the next
   task automatic wr(logic [3:0] s, logic [7:0] d);
      @(negedge clk);
      sel = s;
      wdat = d;
      swr = 1'h1;
      @(negedge clk);
      swr = 1'h0;
   endtask
   task automatic chk_reg(string what, logic [3:0] s, logic [7:0] exp);
      @(negedge clk);
      sel = s;
      #1 chk(what, exp, rdat);
   endtask
   task automatic set3(logic [3:0] s, logic [21:0] a);
      wr(s, a[7:0]);
      wr(s + 4'h1, a[15:8]);
      wr(s + 4'h2, {2'h0, a[21:16]});
   endtask
   // Table op pulse; latch is settled two edges later
   task automatic tbl(logic rd_op, logic [1:0] m);
      @(negedge clk);
      trd = rd_op;
      twr = !rd_op;
      mode = m;
      #1 chk("stall", {7'h0, rd_op}, {7'h0, stall});
      @(negedge clk);
      trd = 1'h0;
      twr = 1'h0;
      repeat (2) @(negedge clk);
   endtask
   // Command, optional unlock, go; waits for go to drop under a bound
   task automatic op(logic [2:0] cmd, logic unl, logic [7:0] ctl, logic w);
      int i;
      wr(`NTP_SFR_CMD, {5'h0, cmd});
      if (unl) begin
         wr(`NTP_SFR_LOCK, `NTP_KEY1);
         wr(`NTP_SFR_LOCK, `NTP_KEY2);
      end
      wr(`NTP_SFR_CTRL, ctl);
      if (!w) return;
      sel = `NTP_SFR_CTRL;
      i = 0;
      #1;
      while (rdat[0] !== 1'h0 && i < 3000) begin
         @(negedge clk);
         #1;
         i++;
      end
      chk("go", 8'h00, {7'h0, rdat[0]});
   endtask
   task automatic t_ptr;
      set3(`NTP_SFR_PTRL, 22'h3F1234);
      chk_reg("ptr_l", `NTP_SFR_PTRL, 8'h34);
      chk_reg("ptr_u", `NTP_SFR_PTRU, 8'h3F);
      // Carry and borrow must not reach the space bit
      set3(`NTP_SFR_PTRL, 22'h3FFFFF);
      tbl(1'h1, `NTP_TOP_POSTINC);
      chk_reg("inc_u", `NTP_SFR_PTRU, 8'h20);
      chk_reg("inc_l", `NTP_SFR_PTRL, 8'h00);
      tbl(1'h1, `NTP_TOP_POSTDEC);
      chk_reg("dec_u", `NTP_SFR_PTRU, 8'h3F);
      chk_reg("dec_h", `NTP_SFR_PTRH, 8'hFF);
   endtask
   task automatic t_read;
      set3(`NTP_SFR_PTRL, 22'h000101);
      tbl(1'h1, `NTP_TOP_NONE);
      chk_reg("odd_byte", `NTP_SFR_LATCH, 8'h25);
      chk_reg("none_l", `NTP_SFR_PTRL, 8'h01);
      tbl(1'h1, `NTP_TOP_PREINC);
      chk_reg("pre_byte", `NTP_SFR_LATCH, 8'h81);
      chk_reg("pre_l", `NTP_SFR_PTRL, 8'h02);
   endtask
   task automatic t_page;
      logic [15:0] w;
      wr(`NTP_SFR_LATCH, 8'h3C);
      set3(`NTP_SFR_PTRL, 22'h3F0005);
      tbl(1'h0, `NTP_TOP_POSTINC);
      chk_reg("wr_l", `NTP_SFR_PTRL, 8'h06);
      set3(`NTP_SFR_ADRL, 22'h000277);
      op(`NTP_CMD_PAGE_WR, 1'h1, 8'h09, 1'h1);
      chk_reg("done", `NTP_SFR_CTRL, 8'h0A);
      chk("irq", 8'h01, {7'h0, irq});
      w = ntp_flash_model_i.peek(21'h000102);
      chk("page", 8'h3C, w[15:8]);
   endtask
   task automatic t_cmds;
      logic [15:0] w;
      op(`NTP_CMD_PAGE_RD, 1'h0, 8'h01, 1'h1);
      chk_reg("rd_done", `NTP_SFR_CTRL, 8'h02);
      // Copy the page just read elsewhere: the buffer must now hold the flash bytes
      set3(`NTP_SFR_ADRL, 22'h000300);
      op(`NTP_CMD_PAGE_WR, 1'h1, 8'h01, 1'h1);
      w = ntp_flash_model_i.peek(21'h000182);
      chk("copy", 8'h3C, w[15:8]);
      op(`NTP_CMD_PAGE_ER, 1'h0, 8'h01, 1'h1);
      chk_reg("no_key", `NTP_SFR_CTRL, 8'h04);
      set3(`NTP_SFR_ADRL, 22'h3FFFFC);
      op(`NTP_CMD_BYTE_RD, 1'h0, 8'h01, 1'h1);
      chk_reg("id_rd", `NTP_SFR_DAT, 8'h5A);
      op(`NTP_CMD_BYTE_WR, 1'h1, 8'h01, 1'h1);
      chk_reg("id_ro", `NTP_SFR_CTRL, 8'h04);
      // Second config write may not lift protection but erases other bits
      set3(`NTP_SFR_ADRL, 22'h300000);
      wr(`NTP_SFR_DAT, 8'h0E);
      op(`NTP_CMD_BYTE_WR, 1'h1, 8'h01, 1'h1);
      wr(`NTP_SFR_DAT, 8'hF1);
      op(`NTP_CMD_BYTE_WR, 1'h1, 8'h01, 1'h1);
      wr(`NTP_SFR_DAT, 8'h00);
      op(`NTP_CMD_BYTE_RD, 1'h0, 8'h01, 1'h1);
      chk_reg("cfg", `NTP_SFR_DAT, 8'hF0);
   endtask
   task automatic t_cut;
      set3(`NTP_SFR_ADRL, 22'h000200);
      op(`NTP_CMD_PAGE_WR, 1'h1, 8'h01, 1'h0);
      repeat (5) @(negedge clk);
      wdrst = 1'h1;
      rst_n = 1'h0;
      repeat (3) @(negedge clk);
      rst_n = 1'h1;
      wdrst = 1'h0;
      chk_reg("cut_err", `NTP_SFR_CTRL, 8'h04);
   endtask
   task automatic stop_test;
      $display("Checks made %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'h1;
      t_ptr();
      t_read();
      t_page();
      t_cmds();
      t_cut();
      stop_test();
   end
endmodule // ntp_table_nvm_tb
`default_nettype wire
